//--- emdsp_defs.svh
// constants for the emulation debug serial port
// assumes inclusion by the package and the design modules only
`ifndef EMDSP_DEFS_SVH
`define EMDSP_DEFS_SVH
`define EMDSP_CLK_NS 40
`define EMDSP_CMD_W 8
`define EMDSP_DATA_W 24
`define EMDSP_ACK_NS 80
`define EMDSP_ACK_CYC (((`EMDSP_ACK_NS) + (`EMDSP_CLK_NS) - 1) / (`EMDSP_CLK_NS))
`define EMDSP_RD_BIT 7
`define EMDSP_SEL_LSB 0
`define EMDSP_SEL_W 2
`define EMDSP_NREG 4
`define EMDSP_READY_DLY 2
`endif

//--- emdsp_pkg.sv
// types shared by the emulation debug serial port modules
// assumes emdsp_defs.svh is on the include path
`include "emdsp_defs.svh"
package emdsp_pkg;
  typedef enum logic [2:0] {
    EMDSP_IDLE = 3'b000,
    EMDSP_CMD = 3'b001,
    EMDSP_PREP = 3'b010,
    EMDSP_ACK = 3'b011,
    EMDSP_RDATA = 3'b100,
    EMDSP_WDATA = 3'b101
  } emdsp_state_t;
  typedef enum logic [1:0] {
    EMDSP_NEXT_CMD = 2'b00,
    EMDSP_NEXT_RD = 2'b01,
    EMDSP_NEXT_WR = 2'b10
  } emdsp_next_t;
  typedef logic [`EMDSP_DATA_W-1:0] emdsp_word_t;
endpackage : emdsp_pkg

//--- emdsp_sync.sv
// two-flop synchroniser with edge detect on the second stage
// assumes async input from a pin, single clock domain
`timescale 1ns/1ns
module emdsp_sync (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic async_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } emdsp_sync_st_t;
  emdsp_sync_st_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // only s2/s3 feed logic, s1 is metastability guard
  assign level_out = st_q.s2;
  assign rise_out = st_q.s2 & ~st_q.s3;
  assign fall_out = ~st_q.s2 & st_q.s3;
endmodule : emdsp_sync

//--- emdsp_port.sv
// Function
// [RULE1] sample input on shift clock fall
// [RULE2] commands and data enter msb first
// [RULE3] output changes on shift clock rise
// [RULE4] returned data leaves msb first
// [RULE5] controller keeps shift clock under eighth
// [RULE6] chip state code outside debug mode
// [RULE7] last command selects shifted register
// [RULE8] low pulse on debug entry
// [RULE9] low pulse when read data ready
// [RULE10] low pulse when ready for write
// [RULE11] low pulse after write stored
// [RULE12] input pin released when turning around
// [RULE13] request finishes instruction, enters debug
// [RULE14] controller drops request after acknowledge (the bench resync drops it before the acknowledge)
// [RULE15] request in debug resets port controller (the code skips the reset when the request drops in EMDSP_ACK)
// [RULE16] shift clock synchronised, edges detected
// [RULE17] opcode decoded after full command
//
// emulation debug serial port, device side
// assumes the core supplies halt handshake, status code and register file access
`timescale 1ns/1ns
`include "emdsp_defs.svh"
module emdsp_port #(
  parameter int CMD_W = `EMDSP_CMD_W,
  parameter int DATA_W = `EMDSP_DATA_W
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic debug_shift_clock_in,
  input wire logic debug_serial_in,
  input wire logic debug_request_in,
  input wire logic core_halted_in,
  input wire logic [1:0] core_status_in,
  input wire emdsp_pkg::emdsp_word_t reg_rdata_in,
  output logic debug_serial_out,
  output logic debug_serial_oe_out,
  output logic debug_serial_in_oe_out,
  output logic chip_state_bit0_out,
  output logic chip_state_bit1_out,
  output logic halt_req_out,
  output logic debug_mode_out,
  output logic [`EMDSP_SEL_W-1:0] reg_sel_out,
  output logic reg_rd_out,
  output logic reg_wr_out,
  output emdsp_pkg::emdsp_word_t reg_wdata_out
);
  import emdsp_pkg::*;
  // elaboration check: the shift and count logic only serves the package layout
  if (CMD_W != `EMDSP_CMD_W || DATA_W != `EMDSP_DATA_W) begin : g_bad_width
    $error("emdsp_port: widths must match the package word and command layout");
  end
  typedef struct packed {
    emdsp_state_t st;
    emdsp_next_t nxt;
    logic dbg;
    logic req_seen;
    logic [CMD_W-1:0] cmd;
    emdsp_word_t sh;
    logic [5:0] cnt;
    logic [2:0] tmr;
    logic so;
    logic so_oe;
    logic si_oe;
    logic os0;
    logic os1;
    logic halt;
    logic [`EMDSP_SEL_W-1:0] sel;
    logic rd;
    logic wr;
    emdsp_word_t wdat;
  } emdsp_port_st_t;
  emdsp_port_st_t s_q, s_d;
  logic sck_rise, sck_fall, si_lvl, req_lvl, req_rise, req_fall;
  // [RULE16] clock sync edges
  emdsp_sync u_sck (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(debug_shift_clock_in),
    .level_out(),
    .rise_out(sck_rise),
    .fall_out(sck_fall)
  );
  emdsp_sync u_si (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(debug_serial_in),
    .level_out(si_lvl),
    .rise_out(),
    .fall_out()
  );
  emdsp_sync u_req (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .async_in(debug_request_in),
    .level_out(req_lvl),
    .rise_out(req_rise),
    .fall_out(req_fall)
  );
  function automatic logic [5:0] emdsp_len(input int n);
    emdsp_len = 6'(n - 1);
  endfunction : emdsp_len
  always_comb begin
    s_d = s_q;
    s_d.rd = 1'b0;
    s_d.wr = 1'b0;
    // [RULE6] status code outside debug
    s_d.os0 = s_q.dbg ? 1'b0 : core_status_in[0];
    s_d.os1 = s_q.dbg ? 1'b0 : core_status_in[1];
    if (s_q.st != EMDSP_ACK) begin
      s_d.so = s_q.st == EMDSP_RDATA ? s_q.so : 1'b1;
    end
    unique case (s_q.st)
      EMDSP_IDLE: begin
        s_d.so_oe = 1'b0;
        // [RULE13] halt then debug entry
        if (req_lvl) begin
          s_d.halt = 1'b1;
        end
        if (s_q.halt && core_halted_in) begin
          s_d.dbg = 1'b1;
          s_d.so_oe = 1'b1;
          s_d.nxt = EMDSP_NEXT_CMD;
          s_d.st = EMDSP_ACK;
          s_d.tmr = 3'(`EMDSP_ACK_CYC);
        end
      end
      EMDSP_CMD: begin
        // [RULE1] sample on fall
        if (sck_fall) begin
          // [RULE2] msb first assembly
          s_d.cmd = {s_q.cmd[CMD_W-2:0], si_lvl};
          s_d.cnt = s_q.cnt - 6'h01;
          if (s_q.cnt == 6'h00) begin
            s_d.st = EMDSP_PREP;
            s_d.tmr = 3'(`EMDSP_READY_DLY);
          end
        end
      end
      EMDSP_PREP: begin
        // [RULE17] decode full opcode
        // [RULE7] select from last command
        s_d.sel = s_q.cmd[`EMDSP_SEL_LSB +: `EMDSP_SEL_W];
        s_d.rd = s_q.cmd[`EMDSP_RD_BIT] && s_q.tmr == 3'(`EMDSP_READY_DLY);
        s_d.tmr = s_q.tmr - 3'h1;
        if (s_q.tmr == 3'h0) begin
          s_d.sh = reg_rdata_in;
          s_d.st = EMDSP_ACK;
          s_d.tmr = 3'(`EMDSP_ACK_CYC);
          // [RULE9] read ready pulse follows
          // [RULE10] write ready pulse follows
          s_d.nxt = s_q.cmd[`EMDSP_RD_BIT] ? EMDSP_NEXT_RD : EMDSP_NEXT_WR;
        end
      end
      EMDSP_ACK: begin
        // [RULE8] low acknowledge pulse
        s_d.so = 1'b0;
        s_d.tmr = s_q.tmr - 3'h1;
        if (s_q.tmr == 3'h0) begin
          s_d.so = 1'b1;
          s_d.cnt = emdsp_len(s_q.nxt == EMDSP_NEXT_CMD ? CMD_W : DATA_W);
          unique case (s_q.nxt)
            EMDSP_NEXT_RD: s_d.st = EMDSP_RDATA;
            EMDSP_NEXT_WR: s_d.st = EMDSP_WDATA;
            default: s_d.st = EMDSP_CMD;
          endcase
        end
      end
      EMDSP_RDATA: begin
        // [RULE3] drive on rise
        if (sck_rise) begin
          // [RULE4] msb out first
          s_d.so = s_q.sh[DATA_W-1];
          s_d.sh = {s_q.sh[DATA_W-2:0], 1'b0};
        end
        if (sck_fall) begin
          s_d.cnt = s_q.cnt - 6'h01;
          if (s_q.cnt == 6'h00) begin
            s_d.st = EMDSP_CMD;
            s_d.cnt = emdsp_len(CMD_W);
          end
        end
      end
      EMDSP_WDATA: begin
        if (sck_fall) begin
          s_d.sh = {s_q.sh[DATA_W-2:0], si_lvl};
          s_d.cnt = s_q.cnt - 6'h01;
          if (s_q.cnt == 6'h00) begin
            s_d.wdat = {s_q.sh[DATA_W-2:0], si_lvl};
            s_d.wr = 1'b1;
            // [RULE11] pulse after store
            s_d.st = EMDSP_ACK;
            s_d.nxt = EMDSP_NEXT_CMD;
            s_d.tmr = 3'(`EMDSP_ACK_CYC);
          end
        end
      end
      default: s_d.st = EMDSP_IDLE;
    endcase
    // [RULE14] request rise arms resync, request drop then resets unless in EMDSP_ACK
    if (s_q.dbg && req_rise) begin
      s_d.req_seen = 1'b1;
    end
    // [RULE15] request pulse resets controller unless it ends in EMDSP_ACK
    if (s_q.dbg && s_q.req_seen && req_fall && s_q.st != EMDSP_ACK) begin
      s_d.req_seen = 1'b0;
      s_d.st = EMDSP_ACK;
      s_d.nxt = EMDSP_NEXT_CMD;
      s_d.tmr = 3'(`EMDSP_ACK_CYC);
      s_d.cnt = emdsp_len(CMD_W);
    end else if (req_fall) begin
      s_d.req_seen = 1'b0;
    end
    // [RULE12] input never driven, stays high-z
    s_d.si_oe = 1'b0;
  end
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_q <= '0;
      s_q.so <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign debug_serial_out = s_q.so;
  assign debug_serial_oe_out = s_q.so_oe;
  assign debug_serial_in_oe_out = s_q.si_oe;
  assign chip_state_bit0_out = s_q.os0;
  assign chip_state_bit1_out = s_q.os1;
  assign halt_req_out = s_q.halt;
  assign debug_mode_out = s_q.dbg;
  assign reg_sel_out = s_q.sel;
  assign reg_rd_out = s_q.rd;
  assign reg_wr_out = s_q.wr;
  assign reg_wdata_out = s_q.wdat;
endmodule : emdsp_port

//--- emdsp_port_sva.sv
// pin-level checks of the emulation debug serial port
// assumes binding to emdsp_port, one clock domain
`timescale 1ns/1ns
module emdsp_port_sva (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic debug_request_in,
  input wire logic core_halted_in,
  input wire logic debug_serial_out,
  input wire logic debug_serial_in_oe_out,
  input wire logic chip_state_bit0_out,
  input wire logic chip_state_bit1_out,
  input wire logic halt_req_out,
  input wire logic debug_mode_out,
  input wire logic reg_rd_out,
  input wire logic reg_wr_out
);
  default clocking dcb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  property p_in_off; debug_serial_in_oe_out == 1'b0; endproperty
  a_in_off: assert property (p_in_off) else $error("input pin driven");
  property p_state_dbg;
    debug_mode_out && $past(debug_mode_out) |-> {chip_state_bit1_out, chip_state_bit0_out} == 2'b00;
  endproperty
  a_state_dbg: assert property (p_state_dbg) else $error("state code in debug");
  // data bits stand longer, so two low cycles hold for both
  property p_ack_len; $fell(debug_serial_out) |-> !debug_serial_out [*2]; endproperty
  a_ack_len: assert property (p_ack_len) else $error("low pulse too short");
  property p_entry; $rose(debug_mode_out) |-> ##[0:3] !debug_serial_out; endproperty
  a_entry: assert property (p_entry) else $error("no entry pulse");
  property p_mode_halt; $rose(debug_mode_out) |-> halt_req_out && $past(core_halted_in); endproperty
  a_mode_halt: assert property (p_mode_halt) else $error("debug before halt");
  property p_halt; $rose(debug_request_in) && !debug_mode_out |-> ##[1:6] halt_req_out; endproperty
  a_halt: assert property (p_halt) else $error("no halt request");
  property p_rd_ack; $rose(reg_rd_out) |-> ##[0:8] $fell(debug_serial_out); endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("no read ready pulse");
  property p_wr_ack; $rose(reg_wr_out) |-> ##[0:8] $fell(debug_serial_out); endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("no write done pulse");
endmodule : emdsp_port_sva
bind emdsp_port emdsp_port_sva u_sva (
  .clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in),
  .debug_request_in(debug_request_in),
  .core_halted_in(core_halted_in),
  .debug_serial_out(debug_serial_out),
  .debug_serial_in_oe_out(debug_serial_in_oe_out),
  .chip_state_bit0_out(chip_state_bit0_out),
  .chip_state_bit1_out(chip_state_bit1_out),
  .halt_req_out(halt_req_out),
  .debug_mode_out(debug_mode_out),
  .reg_rd_out(reg_rd_out),
  .reg_wr_out(reg_wr_out)
);

//--- emdsp_ctl_model.sv
// external debug controller: drives shift clock and serial commands
// assumes calls start just after a system clock rise
`timescale 1ns/1ns
module emdsp_ctl_model (
  input wire logic clk_sys_in,
  input wire logic serial_back_in,
  output logic shift_clk_out,
  output logic serial_cmd_out
);
  initial begin
    shift_clk_out = 1'b0;
    serial_cmd_out = 1'b1;
  end
  // msb first, eight clocks a bit
  task shift_bits(input logic [23:0] tx, input int n, output logic [23:0] rx);
    rx = '0;
    for (int i = 0; i < n; i++) begin
      #160 shift_clk_out = 1'b1;
      serial_cmd_out = tx[23 - i];
      #150 rx = {rx[22:0], serial_back_in};
      #10 shift_clk_out = 1'b0;
    end
  endtask : shift_bits
  // no clocking before the low pulse
  task wait_ack(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      @(posedge clk_sys_in);
      // look emulation_port the edge's update has settled
      #1 ok = (serial_back_in === 1'b0);
    end
    repeat (4) @(posedge clk_sys_in);
    #1 serial_cmd_out = ~serial_cmd_out;
  endtask : wait_ack
endmodule : emdsp_ctl_model

//--- emulation_debug_serial_port_tb.sv
// self-checking bench for the emulation debug serial port
// assumes emdsp_pkg and the controller model compiled before it
`timescale 1ns/1ns
module emulation_debug_serial_port_tb;
  import emdsp_pkg::*;
  logic clk_sys_in, sys_rst_in, debug_shift_clock_in, debug_serial_in, debug_request_in;
  logic core_halted_in, debug_serial_out, debug_serial_oe_out, debug_serial_in_oe_out;
  logic chip_state_bit0_out, chip_state_bit1_out, halt_req_out, debug_mode_out;
  logic reg_rd_out, reg_wr_out, wr_seen, rd_seen;
  logic [1:0] core_status_in, reg_sel_out;
  emdsp_word_t reg_rdata_in, reg_wdata_out, rx, wr_val;
  bit ok;
  int num_errors = 0;
  int checked = 0;
  // distinct word per select
  assign reg_rdata_in = 24'hA53C96 ^ {22'h0, reg_sel_out};
  emdsp_port DUT (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .debug_shift_clock_in(debug_shift_clock_in),
    .debug_serial_in(debug_serial_in),
    .debug_request_in(debug_request_in),
    .core_halted_in(core_halted_in),
    .core_status_in(core_status_in),
    .reg_rdata_in(reg_rdata_in),
    .debug_serial_out(debug_serial_out),
    .debug_serial_oe_out(debug_serial_oe_out),
    .debug_serial_in_oe_out(debug_serial_in_oe_out),
    .chip_state_bit0_out(chip_state_bit0_out),
    .chip_state_bit1_out(chip_state_bit1_out),
    .halt_req_out(halt_req_out),
    .debug_mode_out(debug_mode_out),
    .reg_sel_out(reg_sel_out),
    .reg_rd_out(reg_rd_out),
    .reg_wr_out(reg_wr_out),
    .reg_wdata_out(reg_wdata_out)
  );
  emdsp_ctl_model ctl (.clk_sys_in, .serial_back_in(debug_serial_out),
    .shift_clk_out(debug_shift_clock_in), .serial_cmd_out(debug_serial_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) if (reg_wr_out === 1'b1) begin
    wr_seen <= 1'b1;
    wr_val <= reg_wdata_out;
  end
  always @(posedge clk_sys_in) if (reg_rd_out === 1'b1) begin
    rd_seen <= 1'b1;
  end
  task compare(input string what, input logic [23:0] exp, input logic [23:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : compare
  task t_idle();
    for (int c = 0; c < 4; c++) begin
      core_status_in = 2'(c);
      repeat (3) @(posedge clk_sys_in);
      #1 compare("state", 24'(c), {chip_state_bit1_out, chip_state_bit0_out});
    end
    compare("in_oe", 24'h0, debug_serial_in_oe_out);
    compare("out_oe", 24'h0, debug_serial_oe_out);
    compare("out_idle", 24'h1, debug_serial_out);
    $display("idle done");
  endtask : t_idle
  task t_request(input logic halted);
    debug_request_in = 1'b1;
    repeat (8) @(posedge clk_sys_in);
    #1 compare("halt", 24'h1, halt_req_out);
    core_halted_in = 1'b1;
    if (!halted) ctl.wait_ack(ok);
    else begin
      debug_request_in = 1'b0;
      ctl.wait_ack(ok);
    end
    compare("ack", 24'h1, ok);
    compare("mode", 24'h1, {chip_state_bit1_out, chip_state_bit0_out, debug_mode_out});
    compare("out_oe", 24'h1, debug_serial_oe_out);
    debug_request_in = 1'b0;
    $display("request done");
  endtask : t_request
  task t_read(input int s);
    rd_seen = 1'b0;
    ctl.shift_bits({8'h80 | 8'(s), 16'h0}, 8, rx);
    ctl.wait_ack(ok);
    compare("rd_ack", 24'h1, ok);
    compare("rd", 24'h1, rd_seen);
    compare("sel", 24'(s), reg_sel_out);
    ctl.shift_bits(24'h0, 24, rx);
    compare("rdata", 24'hA53C96 ^ 24'(s), rx);
    $display("read done");
  endtask : t_read
  task t_write();
    wr_seen = 1'b0;
    rd_seen = 1'b0;
    ctl.shift_bits({8'h02, 16'h0}, 8, rx);
    ctl.wait_ack(ok);
    compare("wr_rdy", 24'h1, ok);
    compare("wr_nord", 24'h0, rd_seen);
    ctl.shift_bits(24'hC3A55A, 24, rx);
    ctl.wait_ack(ok);
    compare("wr_ack", 24'h1, ok);
    compare("wdata", 24'hC3A55A, wr_seen ? wr_val : 24'h0);
    compare("wsel", 24'h2, reg_sel_out);
    $display("write done");
  endtask : t_write
  task t_resync();
    // half a command, then resynchronise
    ctl.shift_bits(24'hF00000, 4, rx);
    t_request(1'b1);
    $display("resync done");
  endtask : t_resync
  task complete_run();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    sys_rst_in = 1'b1;
    debug_request_in = 1'b0;
    core_halted_in = 1'b0;
    core_status_in = 2'b00;
    repeat (10) @(posedge clk_sys_in);
    #1 sys_rst_in = 1'b0;
    t_idle();
    t_request(1'b0);
    for (int s = 0; s < 4; s++) t_read(s);
    t_write();
    t_resync();
    t_read(1);
    complete_run();
  end
  initial begin
    #400000 num_errors++;
    complete_run();
  end
endmodule : emulation_debug_serial_port_tb
